// File: include/sar_adc_pkg.sv
/*
  package for the successive-approximation converter control block:
  clock rates, step counts, register map, state codes and carriers.
  assumes a single 20 MHz system clock and an apb master with 32-bit data.
*/
package sar_adc_pkg;

  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ = 20000000;
  localparam int unsigned CONV_CLK_HZ = 640000;
  // rounds down: converter clock a little fast, still inside limits
  localparam int unsigned CONV_DIV = SYS_CLK_HZ / CONV_CLK_HZ;
  localparam int unsigned RES_BITS = 8;
  localparam int unsigned STEP_CLKS = 8;
  localparam int unsigned EOC_MAX_CONV_CLKS = 8;
  localparam int unsigned CONV_TIME_MIN_US = 90;
  localparam int unsigned CONV_TIME_MAX_US = 116;
  localparam int unsigned CONV_MIN_CYC = CONV_TIME_MIN_US * (SYS_CLK_HZ / 1000000);
  localparam int unsigned CONV_MAX_CYC = CONV_TIME_MAX_US * (SYS_CLK_HZ / 1000000);

  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFS = 32'h0000_0004;
  localparam logic [31:0] MASK_OFS = 32'h0000_0008;
  localparam logic [31:0] RESULT_OFS = 32'h0000_000c;
  localparam int unsigned CTRL_FREE_RUN_BIT = 0;
  localparam int unsigned EV_DONE_BIT = 0;
  localparam int unsigned EV_ABORT_BIT = 1;
  localparam int unsigned EV_BITS = 2;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic DONE_RST = 1'b1;

  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ARMED = 5'b00010,
    ST_CONV = 5'b00100,
    ST_LOAD = 5'b01000,
    ST_DONE = 5'b10000
  } conv_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage : sar_adc_pkg

// File: core/sar_adc_ctrl.sv
/*
  control logic of an 8-channel, 8-bit successive-approximation converter:
  channel latch, approximation register, end-of-conversion, gated result
  outputs, and an apb register file with a masked interrupt.
  assumes the ladder and comparator sit outside; comp_above comes from
  the comparator and all pin inputs are asynchronous to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module sar_adc_ctrl (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire sar_adc_pkg::apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic ale,
  input wire logic [2:0] addr,
  input wire logic conversion_trigger,
  input wire logic output_enable,
  input wire logic comp_above,
  output logic [2:0] chan_sel,
  output logic [7:0] chan_onehot,
  output logic [7:0] ladder_code,
  output logic conversion_done,
  output logic [7:0] data_out,
  output logic data_oe
);

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  logic [6:0] s1_q;
  logic [6:0] s2_q;
  logic ale_s, trig_pin_s, oe_s, comp_s;
  logic [2:0] addr_s;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {ale, addr, conversion_trigger, output_enable, comp_above};
      s2_q <= s1_q;
    end
  end

  assign ale_s = s2_q[6];
  assign addr_s = s2_q[5:3];
  assign trig_pin_s = s2_q[2];
  assign oe_s = s2_q[1];
  assign comp_s = s2_q[0];

  // --------------------------------------------------------------
  // converter clock enable
  // --------------------------------------------------------------
  logic [5:0] div_q;
  logic tick;

  always_ff @(posedge core_clk) begin
    if (sys_rst || div_q == 6'(sar_adc_pkg::CONV_DIV - 1)) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 6'd1;
    end
  end

  assign tick = (div_q == 6'(sar_adc_pkg::CONV_DIV - 1));

  // --------------------------------------------------------------
  // edges and channel latch
  // --------------------------------------------------------------
  logic ale_p_q, trig_p_q, free_run_q, done_q;
  logic trig_eff, trig_rise, trig_fall, ale_rise;
  logic [2:0] chan_q;
  logic [7:0] onehot_q;

  assign trig_eff = trig_pin_s | (free_run_q & done_q);
  assign trig_rise = trig_eff & ~trig_p_q;
  assign trig_fall = ~trig_eff & trig_p_q;
  assign ale_rise = ale_s & ~ale_p_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ale_p_q <= 1'b0;
      trig_p_q <= 1'b0;
    end else begin
      ale_p_q <= ale_s;
      trig_p_q <= trig_eff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      chan_q <= '0;
      onehot_q <= 8'h01;
    end else if (ale_rise) begin
      chan_q <= addr_s;
      onehot_q <= 8'h01 << addr_s;
    end
  end

  assign chan_sel = chan_q;
  assign chan_onehot = onehot_q;

  // --------------------------------------------------------------
  // approximation sequencer
  // --------------------------------------------------------------
  sar_adc_pkg::conv_state_t state_q;
  logic [7:0] sar_q, sar_dec, result_q;
  logic [2:0] bit_q, step_q;
  logic last_step;

  always_comb begin
    sar_dec = sar_q;
    sar_dec[bit_q] = comp_s;
  end

  assign last_step = tick && step_q == 3'(sar_adc_pkg::STEP_CLKS - 1);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= sar_adc_pkg::ST_IDLE;
      sar_q <= '0;
      bit_q <= 3'd7;
      step_q <= '0;
      done_q <= sar_adc_pkg::DONE_RST;
      result_q <= '0;
    end else if (trig_rise) begin
      state_q <= sar_adc_pkg::ST_ARMED;
      sar_q <= '0;
      done_q <= 1'b0;
    end else begin
      unique case (state_q)
        sar_adc_pkg::ST_ARMED: begin
          if (trig_fall) begin
            state_q <= sar_adc_pkg::ST_CONV;
            sar_q <= 8'h80;
            bit_q <= 3'd7;
            step_q <= '0;
          end
        end
        sar_adc_pkg::ST_CONV: begin
          if (last_step) begin
            step_q <= '0;
            if (bit_q == 3'd0) begin
              sar_q <= sar_dec;
              result_q <= sar_dec;
              state_q <= sar_adc_pkg::ST_LOAD;
            end else begin
              sar_q <= sar_dec | (8'h01 << (bit_q - 3'd1));
              bit_q <= bit_q - 3'd1;
            end
          end else if (tick) begin
            step_q <= step_q + 3'd1;
          end
        end
        sar_adc_pkg::ST_LOAD: begin
          if (tick) begin
            state_q <= sar_adc_pkg::ST_DONE;
            done_q <= 1'b1;
          end
        end
        sar_adc_pkg::ST_IDLE, sar_adc_pkg::ST_DONE: begin
        end
      endcase
    end
  end

  assign ladder_code = sar_q;
  assign conversion_done = done_q;

  // --------------------------------------------------------------
  // result outputs
  // --------------------------------------------------------------
  // pins float unless the host enables them; the pad applies oe
  assign data_out = result_q;
  assign data_oe = oe_s;

  // --------------------------------------------------------------
  // apb registers and interrupt
  // --------------------------------------------------------------
  logic [1:0] status_q, mask_q, ev, clr;
  logic [31:0] rdata_q, rd_mux;
  logic irq_q, wr_acc, hit, busy;

  assign busy = (state_q == sar_adc_pkg::ST_CONV) || (state_q == sar_adc_pkg::ST_LOAD);
  assign ev[sar_adc_pkg::EV_DONE_BIT] = (state_q == sar_adc_pkg::ST_LOAD) && tick && !trig_rise;
  assign ev[sar_adc_pkg::EV_ABORT_BIT] = trig_rise && busy;
  assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign hit = apb_req.paddr == sar_adc_pkg::CTRL_OFS || apb_req.paddr == sar_adc_pkg::STATUS_OFS
    || apb_req.paddr == sar_adc_pkg::MASK_OFS || apb_req.paddr == sar_adc_pkg::RESULT_OFS;
  assign clr = (wr_acc && apb_req.paddr == sar_adc_pkg::STATUS_OFS) ? apb_req.pwdata[1:0] : 2'h0;

  always_comb begin
    rd_mux = '0;
    unique case (apb_req.paddr)
      sar_adc_pkg::CTRL_OFS: rd_mux = {31'h0, free_run_q};
      sar_adc_pkg::STATUS_OFS: rd_mux = {30'h0, status_q};
      sar_adc_pkg::MASK_OFS: rd_mux = {30'h0, mask_q};
      sar_adc_pkg::RESULT_OFS: rd_mux = {15'h0, busy, 5'h0, chan_q, result_q};
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      free_run_q <= sar_adc_pkg::CTRL_RST;
      mask_q <= sar_adc_pkg::MASK_RST;
      rdata_q <= '0;
    end else begin
      if (wr_acc && apb_req.paddr == sar_adc_pkg::CTRL_OFS) begin
        free_run_q <= apb_req.pwdata[sar_adc_pkg::CTRL_FREE_RUN_BIT];
      end
      if (wr_acc && apb_req.paddr == sar_adc_pkg::MASK_OFS) begin
        mask_q <= apb_req.pwdata[1:0];
      end
      // captured in setup so the access phase sees a flopped value
      if (apb_req.psel && !apb_req.penable) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // set wins over a same-cycle clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      status_q <= '0;
      irq_q <= 1'b0;
    end else begin
      status_q <= (status_q & ~clr) | ev;
      irq_q <= |(((status_q & ~clr) | ev) & mask_q);
    end
  end

  assign irq = irq_q;
  assign prdata = rdata_q;
  assign pready = 1'b1;
  assign pslverr = apb_req.psel && apb_req.penable && !hit;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  logic [3:0] dec_cnt_q;
  logic [11:0] cyc_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst || trig_rise) begin
      dec_cnt_q <= '0;
      cyc_q <= '0;
    end else if (busy) begin
      cyc_q <= cyc_q + 12'd1;
      if (state_q == sar_adc_pkg::ST_CONV && last_step) begin
        dec_cnt_q <= dec_cnt_q + 4'd1;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_chan_hold;
    !ale_rise |=> $stable(chan_q);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel changed without strobe");

  property p_chan_code;
    ale_rise |=> chan_q == $past(addr_s) && onehot_q[chan_q] && $onehot(onehot_q);
  endproperty
  a_chan_code: assert property (p_chan_code) else $error("channel decode wrong");

  property p_sar_clear;
    trig_rise |=> sar_q == 8'h00 && state_q == sar_adc_pkg::ST_ARMED;
  endproperty
  a_sar_clear: assert property (p_sar_clear) else $error("register not cleared");

  property p_no_early_start;
    state_q == sar_adc_pkg::ST_ARMED && trig_eff |=> state_q != sar_adc_pkg::ST_CONV;
  endproperty
  a_no_early_start: assert property (p_no_early_start) else $error("started while high");

  property p_abort;
    trig_rise && busy |=> state_q == sar_adc_pkg::ST_ARMED && status_q[sar_adc_pkg::EV_ABORT_BIT];
  endproperty
  a_abort: assert property (p_abort) else $error("conversion not aborted");

  property p_free_run;
    free_run_q && !trig_pin_s && state_q == sar_adc_pkg::ST_DONE && done_q && trig_p_q == 1'b0
      |=> state_q == sar_adc_pkg::ST_ARMED ##1 !done_q;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free run did not restart");

  property p_done_fall;
    trig_rise |=> !done_q;
  endproperty
  a_done_fall: assert property (p_done_fall) else $error("done did not fall");

  property p_load_before_done;
    $rose(done_q) |-> $past(state_q) == sar_adc_pkg::ST_LOAD && $stable(result_q)
      && result_q == sar_q;
  endproperty
  a_load_before_done: assert property (p_load_before_done) else $error("result not preloaded");

  property p_eight_steps;
    $rose(done_q) |-> dec_cnt_q == 4'd8;
  endproperty
  a_eight_steps: assert property (p_eight_steps) else $error("wrong step count");

  property p_duration;
    $rose(done_q) |-> cyc_q >= 12'(sar_adc_pkg::CONV_MIN_CYC) && cyc_q <= 12'(sar_adc_pkg::CONV_MAX_CYC);
  endproperty
  a_duration: assert property (p_duration) else $error("conversion time out of range");

  property p_bit_decide;
    state_q == sar_adc_pkg::ST_CONV && last_step && !trig_rise |=> sar_q[$past(bit_q)] == $past(comp_s);
  endproperty
  a_bit_decide: assert property (p_bit_decide) else $error("bit not taken from comparator");

  property p_done_low;
    busy |-> !done_q;
  endproperty
  a_done_low: assert property (p_done_low) else $error("done high in conversion");

  c_full: cover property ($rose(done_q) && !free_run_q);
  c_abort: cover property (trig_rise && state_q == sar_adc_pkg::ST_CONV);
  // restart falls in the very cycle done rises
  c_free: cover property (free_run_q && $rose(done_q) && trig_rise);

endmodule : sar_adc_ctrl

`default_nettype wire

// File: verification/comp_model.sv
/*
  comparator and analog source model facing the converter control block.
  assumes one fixed level per channel, driven by the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module comp_model (
  input wire logic [2:0] chan_sel,
  input wire logic [7:0] ladder_code,
  input wire logic [7:0] levels [8],
  output logic comp_above
);
  // ------------------------------------------------------------
  // comparison
  // ------------------------------------------------------------
  // input at or above the trial code means a one: positive-true code
  assign comp_above = (levels[chan_sel] >= ladder_code);
endmodule : comp_model

`default_nettype wire

// File: verification/sar_adc_ctrl_bench.sv
/*
  self-checking bench for the converter control block: apb tasks, pin
  tasks, conversions, abort, interrupt, output enable and free running.
  assumes the comparator model and the design package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module sar_adc_ctrl_bench;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  sar_adc_pkg::apb_req_t apb_req = '0;
  logic ale = 1'b0;
  logic [2:0] addr = 3'h0;
  logic conversion_trigger = 1'b0;
  logic output_enable = 1'b0;
  logic comp_above;
  logic [31:0] prdata;
  logic pready, pslverr, irq, conversion_done, data_oe;
  logic [2:0] chan_sel;
  logic [7:0] chan_onehot, ladder_code, data_out, d_prev;
  logic [7:0] levels [8] = '{8'h00, 8'h5a, 8'ha5, 8'h81, 8'h7e, 8'h01, 8'hc3, 8'hff};
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int chg_cyc = 0;
  logic [31:0] rd;
  logic er;

  always #25 core_clk = ~core_clk;

  sar_adc_ctrl sar_adc_ctrl_inst (.core_clk(core_clk), .sys_rst(sys_rst), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .ale(ale), .addr(addr),
    .conversion_trigger(conversion_trigger), .output_enable(output_enable),
    .comp_above(comp_above), .chan_sel(chan_sel), .chan_onehot(chan_onehot),
    .ladder_code(ladder_code), .conversion_done(conversion_done), .data_out(data_out),
    .data_oe(data_oe));

  comp_model comp_model_inst (.chan_sel(chan_sel), .ladder_code(ladder_code),
    .levels(levels), .comp_above(comp_above));

  // ------------------------------------------------------------
  // monitor and timeout
  // ------------------------------------------------------------
  // ceiling well above six conversions of about 2100 cycles each
  // counted on the falling edge so the main sequence never races the count
  always @(negedge core_clk) begin
    cyc++;
    if (data_out !== d_prev) chg_cyc = cyc;
    d_prev = data_out;
    if (cyc > 30000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // ------------------------------------------------------------
  // apb master
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    // only the bench timeout ends a wait for pready
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    apb_req <= '0;
  endtask : apb

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp, input string msg);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, msg);
  endtask : rchk

  // ------------------------------------------------------------
  // pin tasks
  // ------------------------------------------------------------
  task automatic pick(input logic [2:0] ch);
    @(posedge core_clk);
    addr <= ch;
    ale <= 1'b1;
    repeat (4) @(posedge core_clk);
    ale <= 1'b0;
    addr <= ~ch;
    repeat (4) @(posedge core_clk);
    chk(chan_sel, ch, "channel number");
    chk(chan_onehot, 8'h01 << ch, "channel decode");
  endtask : pick

  task automatic wait_done(input logic lvl, input int lim, output int n);
    n = 0;
    while (conversion_done !== lvl && n < lim) begin
      @(posedge core_clk);
      n++;
    end
  endtask : wait_done

  task automatic convert(input logic [7:0] exp, input logic [7:0] prev);
    int n;
    @(posedge core_clk);
    conversion_trigger <= 1'b1;
    wait_done(1'b0, 400, n);
    chk(n <= 8 * sar_adc_pkg::CONV_DIV, 1, "done fall delay");
    repeat (20) @(posedge core_clk);
    chk(ladder_code, 8'h00, "trial code held while trigger high");
    chk(conversion_done, 1'b0, "done low while trigger high");
    conversion_trigger <= 1'b0;
    wait_done(1'b1, 3000, n);
    chk(n >= sar_adc_pkg::CONV_MIN_CYC && n <= sar_adc_pkg::CONV_MAX_CYC, 1,
        "conversion time");
    chk(data_out, exp, "result code");
    if (exp !== prev) chk(cyc - chg_cyc, sar_adc_pkg::CONV_DIV, "result lead");
  endtask : convert

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    int n;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    chk(conversion_done, 1'b1, "done after reset");
    chk(data_oe, 1'b0, "pins idle after reset");
    rchk(sar_adc_pkg::CTRL_OFS, 32'h0, "ctrl reset");
    chk(er, 1'b0, "mapped read error");
    rchk(sar_adc_pkg::STATUS_OFS, 32'h0, "status reset");
    rchk(sar_adc_pkg::MASK_OFS, 32'h0, "mask reset");
    rchk(32'h0000_0010, 32'h0, "unmapped read");
    chk(er, 1'b1, "unmapped error");
    for (int c = 0; c < 8; c++) pick(c[2:0]);
    convert(levels[7], 8'h00);
    rchk(sar_adc_pkg::RESULT_OFS, {21'h0, 3'h7, levels[7]}, "result register");
    chk(irq, 1'b0, "masked interrupt");
    apb(1'b1, sar_adc_pkg::MASK_OFS, 32'h1);
    repeat (3) @(posedge core_clk);
    chk(irq, 1'b1, "unmasked interrupt");
    apb(1'b1, sar_adc_pkg::STATUS_OFS, 32'h1);
    repeat (3) @(posedge core_clk);
    chk(irq, 1'b0, "interrupt cleared");
    rchk(sar_adc_pkg::STATUS_OFS, 32'h0, "status cleared");
    output_enable <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(data_oe, 1'b1, "pins driven");
    output_enable <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(data_oe, 1'b0, "pins released");
    pick(3'h0);
    convert(levels[0], levels[7]);
    pick(3'h3);
    @(posedge core_clk);
    conversion_trigger <= 1'b1;
    repeat (5) @(posedge core_clk);
    conversion_trigger <= 1'b0;
    repeat (600) @(posedge core_clk);
    convert(levels[3], levels[0]);
    rchk(sar_adc_pkg::STATUS_OFS, 32'h3, "abort event");
    apb(1'b1, sar_adc_pkg::STATUS_OFS, 32'h3);
    apb(1'b1, sar_adc_pkg::CTRL_OFS, 32'h1);
    pick(3'h6);
    convert(levels[6], levels[3]);
    wait_done(1'b0, 300, n);
    chk(conversion_done, 1'b0, "free running restart");
    apb(1'b1, sar_adc_pkg::CTRL_OFS, 32'h0);
    wait_done(1'b1, 3000, n);
    chk(data_out, levels[6], "free running result");
    end_of_test();
  end
endmodule : sar_adc_ctrl_bench

`default_nettype wire
